// ==== cts_pkg.sv ====
// Purpose: Shared constants and types for the CAN transceiver mode supervisor
// Assumes: 50 MHz reference clock
// Notes: Times are in ns; cycle counts derive from them
package cts_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and times
	localparam int CLK_PERIOD_NS = 20;
	localparam int ENABLE_DELAY_NS = 200000;
	localparam int WAKE_MIN_DOMINANT_NS = 5000;
	localparam int WAKE_MAX_GAP_NS = 1000000;
	localparam int TRANSMIT_DOMINANT_TIMEOUT_NS = 4500000;
	localparam int BUS_DOMINANT_TIMEOUT_NS = 4500000;

	// Least time rounds up, longest time rounds down, never below one cycle
	function automatic int cyc_least(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_longest(input int t_ns);
		int c;
		c = t_ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ENABLE_DELAY_CYC = cyc_least(ENABLE_DELAY_NS);
	localparam int WAKE_MIN_DOMINANT_CYC = cyc_least(WAKE_MIN_DOMINANT_NS);
	localparam int WAKE_MAX_GAP_CYC = cyc_longest(WAKE_MAX_GAP_NS);
	localparam int TRANSMIT_DOMINANT_TIMEOUT_CYC = cyc_least(TRANSMIT_DOMINANT_TIMEOUT_NS);
	localparam int BUS_DOMINANT_TIMEOUT_CYC = cyc_least(BUS_DOMINANT_TIMEOUT_NS);
	localparam int CNT_W = 20;

	////////////////////////////////////////////////////////////////////////////
	// Modes and states
	typedef enum logic [1:0] {
		CTS_OFF = 2'h0,
		CTS_WAKE = 2'h1,
		CTS_RXONLY = 2'h2,
		CTS_NORMAL = 2'h3
	} cts_mode_t;

	typedef enum logic [2:0] {
		CHIP_INIT = 3'h0,
		CHIP_NORMAL = 3'h1,
		CHIP_STOP = 3'h2,
		CHIP_SLEEP = 3'h3,
		CHIP_RESTART = 3'h4,
		CHIP_FAILSAFE = 3'h5
	} cts_chip_t;

	typedef enum logic [2:0] {
		W_IDLE = 3'h0,
		W_DOM1 = 3'h1,
		W_HOLD1 = 3'h2,
		W_GAP = 3'h3,
		W_DOM2 = 3'h4
	} cts_wstate_t;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam cts_mode_t MODE_AT_RESET = CTS_OFF;
	localparam cts_chip_t CHIP_AT_RESET = CHIP_INIT;
	localparam logic TX_AT_RESET = 1'h1;

endpackage

// ==== cts_level_timer.sv ====
// Purpose: Counts how long a level has been held and flags the limit
// Assumes: Level is synchronous to ref_clk
// Notes: Count saturates at LIMIT; a low level restarts it
`timescale 1ns/1ns
`default_nettype none
module cts_level_timer #(
	parameter int LIMIT = 4,
	parameter int W = 20
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Level and result
	input wire logic level,
	output logic expired
);
	import cts_pkg::*;

	logic [W-1:0] cnt;

	////////////////////////////////////////////////////////////////////////////
	// Saturating counter
	always_ff @(posedge ref_clk) begin
		if (rst || !level) begin
			cnt <= '0;
		end else if (cnt != W'(LIMIT)) begin
			cnt <= cnt + 1'h1;
		end
	end

	assign expired = (cnt == W'(LIMIT));

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_timer_needs_level: assert property (@(posedge ref_clk) disable iff (rst)
		expired |-> $past(level))
		else $error("timer expired without a held level");

	chk_timer_drop_clears: assert property (@(posedge ref_clk) disable iff (rst)
		!level |=> !expired)
		else $error("timer stayed expired after the level dropped");

endmodule
`default_nettype wire

// ==== cts_supervisor.sv ====
// Purpose: Mode control and fault supervision of a high-speed CAN transceiver
// Assumes: Chip mode and control strobes come from logic on ref_clk
// Notes: Pins and analog comparator outputs pass two flip-flops first
// Notes on behaviour
// - Transceiver starts Off; Off selectable in every chip mode; bus undriven.
// - In Off mode bus wake activity is ignored and never flagged.
// - Normal mode accepted only while chip is in Normal or Stop mode.
// - In Normal mode transmit input low drives dominant, high recessive.
// - After enabling, only a dominant level starting afterwards reaches the bus.
// - Receiving modes show bus state on receive output, low means dominant.
// - Receive-Only in chip Normal or Stop: driver off, reception continues.
// - Wake-Capable selectable in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// - Bus wake in Wake-Capable drives receive output low until mode changes.
// - Wake needs two long dominant phases split by a short recessive gap.
// - After wake the mode field still reads Wake-Capable, receive output low.
// - Leaving Wake-Capable and returning rearms detection; flag clear not needed.
// - Chip entering Stop, Sleep or Fail-Safe rearms wake detection.
// - Wake in chip Stop or Normal: interrupt low, wake flag, receive low.
// - No automatic Stop to Normal change after wake; controller commands it.
// - Wake in Stop with watchdog off and bus-wake option enables watchdog.
// - Wake in Sleep requests Restart, records source, raises no interrupt.
// - Wake in Restart or Fail-Safe requests Restart, interrupt stays high.
// - Transmit dominant timeout disables driver, sets fault, resumes when recessive.
// - Bus dominant timeout in any mode sets fault, mode unchanged.
// - Supply undervoltage in Normal sets flag, disables transmitter, resumes.
`timescale 1ns/1ns
`default_nettype none
module cts_supervisor #(
	parameter int ENABLE_DELAY_CYC = cts_pkg::ENABLE_DELAY_CYC,
	parameter int WAKE_MIN_CYC = cts_pkg::WAKE_MIN_DOMINANT_CYC,
	parameter int WAKE_GAP_CYC = cts_pkg::WAKE_MAX_GAP_CYC,
	parameter int TX_TIMEOUT_CYC = cts_pkg::TRANSMIT_DOMINANT_TIMEOUT_CYC,
	parameter int BUS_TIMEOUT_CYC = cts_pkg::BUS_DOMINANT_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Protocol controller side
	input wire logic can_transmit_input,
	output logic rx_out,
	// Bus front end
	input wire logic bus_dominant_in,
	input wire logic transceiver_supply_pin_low,
	output logic bus_drive_dominant,
	output logic driver_enable,
	output logic bus_bias_on,
	// Mode control
	input wire logic mode_write,
	input wire cts_pkg::cts_mode_t mode_req,
	input wire cts_pkg::cts_chip_t chip_mode,
	output var cts_pkg::cts_mode_t mode_field,
	// Status flags
	input wire logic wake_flag_clear,
	input wire logic fail_flag_clear,
	input wire logic undervolt_flag_clear,
	output logic bus_wake_flag,
	output logic can_fail_flag,
	output logic transceiver_supply_undervolt_flag,
	// Wake reactions
	input wire logic watchdog_disabled,
	input wire logic watchdog_on_bus_wake,
	output logic int_n,
	output logic chip_restart_req,
	output logic watchdog_enable_req
);
	import cts_pkg::*;

	logic tx_meta, tx_s, bus_meta, bus_s, uv_meta, uv_s;
	cts_chip_t chip_prev;
	logic chip_entry, mode_accept, mode_change;
	logic is_normal, en_done, tx_ok, tx_to, tx_to_d, bus_to, bus_to_d;
	logic uv_act, drv_ok, armed, woken, wake_hit, wake_active;
	cts_wstate_t wstate;
	logic [CNT_W-1:0] wcnt;

	function automatic logic mode_allowed(input cts_mode_t m, input cts_chip_t c);
		logic ok;
		ok = 1'h0;
		case (m)
			CTS_OFF: ok = 1'h1;
			CTS_NORMAL, CTS_RXONLY: ok = (c == CHIP_NORMAL) || (c == CHIP_STOP);
			CTS_WAKE: ok = (c == CHIP_STOP) || (c == CHIP_SLEEP) || (c == CHIP_RESTART)
				|| (c == CHIP_NORMAL) || (c == CHIP_FAILSAFE);
			default: ok = 1'h0;
		endcase
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_meta <= TX_AT_RESET;
			tx_s <= TX_AT_RESET;
			bus_meta <= 1'h0;
			bus_s <= 1'h0;
			uv_meta <= 1'h0;
			uv_s <= 1'h0;
		end else begin
			tx_meta <= can_transmit_input;
			tx_s <= tx_meta;
			bus_meta <= bus_dominant_in;
			bus_s <= bus_meta;
			uv_meta <= transceiver_supply_pin_low;
			uv_s <= uv_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transceiver mode selection
	assign chip_entry = (chip_mode != chip_prev);
	assign mode_accept = mode_write && mode_allowed(mode_req, chip_mode);
	assign mode_change = mode_accept && (mode_req != mode_field);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chip_prev <= CHIP_AT_RESET;
		end else begin
			chip_prev <= chip_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_field <= MODE_AT_RESET;
		end else if (chip_entry && chip_mode == CHIP_FAILSAFE) begin
			mode_field <= CTS_WAKE;
		end else if (mode_accept) begin
			mode_field <= mode_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake arming and wake memory
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			armed <= 1'h0;
		end else if (chip_entry && (chip_mode == CHIP_STOP || chip_mode == CHIP_SLEEP
			|| chip_mode == CHIP_FAILSAFE)) begin
			armed <= 1'h1;
		end else if (mode_change) begin
			armed <= (mode_req == CTS_WAKE);
		end else if (wake_hit) begin
			armed <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			woken <= 1'h0;
		end else if (mode_change) begin
			woken <= 1'h0;
		end else if (wake_hit) begin
			woken <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake pattern filter
	assign wake_active = (mode_field == CTS_WAKE) && armed;

	always_ff @(posedge ref_clk) begin
		if (rst || !wake_active) begin
			wstate <= W_IDLE;
			wcnt <= '0;
			wake_hit <= 1'h0;
		end else begin
			wake_hit <= 1'h0;
			case (wstate)
				W_IDLE: begin
					if (bus_s) begin
						wstate <= W_DOM1;
						wcnt <= CNT_W'(1);
					end
				end
				W_DOM1: begin
					if (!bus_s) begin
						wstate <= W_IDLE;
					end else if (wcnt == CNT_W'(WAKE_MIN_CYC)) begin
						wstate <= W_HOLD1;
					end else begin
						wcnt <= wcnt + 1'h1;
					end
				end
				W_HOLD1: begin
					if (!bus_s) begin
						wstate <= W_GAP;
						wcnt <= CNT_W'(1);
					end
				end
				W_GAP: begin
					if (bus_s) begin
						wstate <= W_DOM2;
						wcnt <= CNT_W'(1);
					end else if (wcnt == CNT_W'(WAKE_GAP_CYC - 1)) begin
						wstate <= W_IDLE;
					end else begin
						wcnt <= wcnt + 1'h1;
					end
				end
				W_DOM2: begin
					if (!bus_s) begin
						wstate <= W_GAP;
						wcnt <= CNT_W'(1);
					end else if (wcnt == CNT_W'(WAKE_MIN_CYC)) begin
						wstate <= W_IDLE;
						wake_hit <= 1'h1;
					end else begin
						wcnt <= wcnt + 1'h1;
					end
				end
				default: begin
					wstate <= W_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Chip reactions to a bus wake; Stop never moves to Normal here
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			int_n <= 1'h1;
			chip_restart_req <= 1'h0;
			watchdog_enable_req <= 1'h0;
		end else begin
			int_n <= !(wake_hit && (chip_mode == CHIP_NORMAL || chip_mode == CHIP_STOP));
			chip_restart_req <= wake_hit && (chip_mode == CHIP_SLEEP
				|| chip_mode == CHIP_RESTART || chip_mode == CHIP_FAILSAFE);
			watchdog_enable_req <= wake_hit && chip_mode == CHIP_STOP
				&& watchdog_disabled && watchdog_on_bus_wake;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_wake_flag <= 1'h0;
		end else if (wake_hit) begin
			bus_wake_flag <= 1'h1;
		end else if (wake_flag_clear) begin
			bus_wake_flag <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enabling delay and transmit gating
	assign is_normal = (mode_field == CTS_NORMAL);

	cts_level_timer #(.LIMIT(ENABLE_DELAY_CYC), .W(CNT_W)) u_enable (
		.ref_clk(ref_clk),
		.rst(rst),
		.level(is_normal),
		.expired(en_done)
	);

	// A dominant level that started before enabling ended stays blocked
	always_ff @(posedge ref_clk) begin
		if (rst || !is_normal || !en_done) begin
			tx_ok <= 1'h0;
		end else if (tx_s) begin
			tx_ok <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault supervision
	cts_level_timer #(.LIMIT(TX_TIMEOUT_CYC), .W(CNT_W)) u_tx_timeout (
		.ref_clk(ref_clk),
		.rst(rst),
		.level(is_normal && !tx_s),
		.expired(tx_to)
	);

	cts_level_timer #(.LIMIT(BUS_TIMEOUT_CYC), .W(CNT_W)) u_bus_timeout (
		.ref_clk(ref_clk),
		.rst(rst),
		.level(bus_s),
		.expired(bus_to)
	);

	assign uv_act = is_normal && uv_s;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_to_d <= 1'h0;
			bus_to_d <= 1'h0;
		end else begin
			tx_to_d <= tx_to;
			bus_to_d <= bus_to;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			can_fail_flag <= 1'h0;
		end else if ((tx_to && !tx_to_d) || (bus_to && !bus_to_d)) begin
			can_fail_flag <= 1'h1;
		end else if (fail_flag_clear) begin
			can_fail_flag <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			transceiver_supply_undervolt_flag <= 1'h0;
		end else if (uv_act) begin
			transceiver_supply_undervolt_flag <= 1'h1;
		end else if (undervolt_flag_clear) begin
			transceiver_supply_undervolt_flag <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus driver and receive output
	assign drv_ok = is_normal && en_done && !tx_to && !uv_act;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			driver_enable <= 1'h0;
			bus_drive_dominant <= 1'h0;
			bus_bias_on <= 1'h0;
		end else begin
			driver_enable <= drv_ok;
			bus_drive_dominant <= drv_ok && tx_ok && !tx_s;
			bus_bias_on <= is_normal || (mode_field == CTS_RXONLY);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_out <= 1'h1;
		end else begin
			case (mode_field)
				CTS_NORMAL, CTS_RXONLY: rx_out <= !bus_s;
				CTS_WAKE: rx_out <= !woken;
				default: rx_out <= 1'h1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_dom_across_enable;
		(is_normal && !en_done && !tx_s) ##1 (is_normal && en_done && !tx_s);
	endsequence

	sequence s_wake_in_run;
		wake_hit && (chip_mode == CHIP_NORMAL || chip_mode == CHIP_STOP);
	endsequence

	chk_off_after_reset: assert property (@(posedge ref_clk) disable iff (rst)
		$past(rst) |-> (mode_field == CTS_OFF) && !driver_enable)
		else $error("transceiver not off after reset");

	chk_off_no_wake: assert property (@(posedge ref_clk) disable iff (rst)
		(mode_field == CTS_OFF) |-> !wake_hit ##1 !bus_wake_flag || $past(bus_wake_flag))
		else $error("wake flagged in off mode");

	chk_normal_chip_ok: assert property (@(posedge ref_clk) disable iff (rst)
		(is_normal && !$past(is_normal)) |->
			($past(chip_mode) == CHIP_NORMAL || $past(chip_mode) == CHIP_STOP))
		else $error("normal mode entered in a forbidden chip mode");

	chk_fresh_dominant: assert property (@(posedge ref_clk) disable iff (rst)
		s_dom_across_enable |=> !bus_drive_dominant)
		else $error("early dominant reached the bus");

	chk_drive_cause: assert property (@(posedge ref_clk) disable iff (rst)
		bus_drive_dominant |-> $past(is_normal) && $past(en_done) && !$past(tx_s))
		else $error("dominant driven without cause");

	chk_rx_follows_bus: assert property (@(posedge ref_clk) disable iff (rst)
		$past(is_normal || mode_field == CTS_RXONLY) |-> (rx_out == !$past(bus_s)))
		else $error("receive output does not follow bus");

	chk_rxonly_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		(mode_field == CTS_RXONLY) |=> !driver_enable ##0 !bus_drive_dominant)
		else $error("driver active in receive-only");

	chk_failsafe_wake: assert property (@(posedge ref_clk) disable iff (rst)
		(chip_entry && chip_mode == CHIP_FAILSAFE) |=> (mode_field == CTS_WAKE))
		else $error("fail-safe did not force wake-capable");

	chk_woken_rx_low: assert property (@(posedge ref_clk) disable iff (rst)
		(woken && mode_field == CTS_WAKE) |=> !rx_out)
		else $error("receive output not low after wake");

	chk_wake_reaction: assert property (@(posedge ref_clk) disable iff (rst)
		s_wake_in_run |=> !int_n && bus_wake_flag ##1 int_n)
		else $error("wake in run mode not signalled");

	chk_sleep_restart: assert property (@(posedge ref_clk) disable iff (rst)
		(wake_hit && chip_mode == CHIP_SLEEP) |=> chip_restart_req && int_n)
		else $error("sleep wake did not request restart");

	chk_tx_timeout: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(tx_to) |=> can_fail_flag && !driver_enable)
		else $error("transmit timeout not handled");

	chk_bus_timeout: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(bus_to) |=> can_fail_flag
			&& ($stable(mode_field) || $past(mode_accept || chip_entry)))
		else $error("bus dominant timeout not flagged");

	chk_undervolt: assert property (@(posedge ref_clk) disable iff (rst)
		uv_act |=> transceiver_supply_undervolt_flag && !driver_enable)
		else $error("undervoltage not handled");

endmodule
`default_nettype wire

// ==== cts_ctrl_model.sv ====
// Purpose: Protocol controller model driving the transmit pin
// Assumes: Bench asks for dominant levels through send_dominant
// Notes: ignore_enable drives early on purpose
`timescale 1ns/1ns
`default_nettype none
module cts_ctrl_model #(
	parameter int ENABLE_CYC = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bench requests
	input wire logic send_dominant,
	input wire logic ignore_enable,
	// Transceiver side
	input wire logic bus_bias_on,
	output logic can_transmit_input
);
	int wait_cnt;
	logic ready;

	////////////////////////////////////////////////////////////////////////////
	// Waits out the enabling delay after the bus is biased
	always_ff @(negedge ref_clk) begin
		if (rst || !bus_bias_on) begin
			wait_cnt <= 0;
		end else if (wait_cnt < ENABLE_CYC + 2) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	assign ready = (wait_cnt >= ENABLE_CYC + 2);

	////////////////////////////////////////////////////////////////////////////
	// Transmit pin, recessive until ready unless ignore_enable is set
	always_ff @(negedge ref_clk) begin
		if (rst) begin
			can_transmit_input <= 1'h1;
		end else begin
			can_transmit_input <= !(send_dominant && (ready || ignore_enable));
		end
	end
endmodule
`default_nettype wire

// ==== can_transceiver_mode_supervisor_tb.sv ====
// Purpose: Self-checking bench for the transceiver mode supervisor
// Assumes: Short counts: enable 8, wake 4, gap 16, timeouts 32
// Notes: Inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module can_transceiver_mode_supervisor_tb;
	import cts_pkg::*;
	logic ref_clk, rst, send_dom, ign_en, bus_dom, uv, mode_write, wfc, ffc, ufc, wd_dis, wd_obw;
	logic can_tx, rx_out, bdd, drv_en, bias, bwf, cff, uvf, int_n, rst_req, wd_req;
	cts_mode_t mode_req, mode_field;
	cts_chip_t chip_mode;
	int n_fail, checks_done, cycles, n_int, n_rst, n_wd;

	cts_ctrl_model ctrl (.ref_clk(ref_clk), .rst(rst), .send_dominant(send_dom),
		.ignore_enable(ign_en), .bus_bias_on(bias), .can_transmit_input(can_tx));

	cts_supervisor #(.ENABLE_DELAY_CYC(8), .WAKE_MIN_CYC(4), .WAKE_GAP_CYC(16),
		.TX_TIMEOUT_CYC(32), .BUS_TIMEOUT_CYC(32)) DUT (.ref_clk(ref_clk), .rst(rst),
		.can_transmit_input(can_tx), .rx_out(rx_out), .bus_dominant_in(bus_dom),
		.transceiver_supply_pin_low(uv), .bus_drive_dominant(bdd), .driver_enable(drv_en),
		.bus_bias_on(bias), .mode_write(mode_write), .mode_req(mode_req), .chip_mode(chip_mode),
		.mode_field(mode_field), .wake_flag_clear(wfc), .fail_flag_clear(ffc),
		.undervolt_flag_clear(ufc), .bus_wake_flag(bwf), .can_fail_flag(cff),
		.transceiver_supply_undervolt_flag(uvf), .watchdog_disabled(wd_dis),
		.watchdog_on_bus_wake(wd_obw), .int_n(int_n), .chip_restart_req(rst_req),
		.watchdog_enable_req(wd_req));

	////////////////////////////////////////////////////////////////////////////
	// Clock, pulse counters and timeout
	always #10 ref_clk = ~ref_clk;

	always @(negedge ref_clk) begin
		if (!int_n) n_int++;
		if (rst_req) n_rst++;
		if (wd_req) n_wd++;
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare and access tasks
	task automatic chk1(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chkm(input cts_mode_t exp);
		checks_done++;
		if (mode_field !== exp) begin
			n_fail++;
			$display("CHECK FAILED mode_field expected %0h seen %0h", exp, mode_field);
		end
	endtask

	task automatic chkn(input string what, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wr_mode(input cts_mode_t m);
		@(negedge ref_clk);
		mode_write = 1'h1;
		mode_req = m;
		@(negedge ref_clk);
		mode_write = 1'h0;
		tick(3);
	endtask

	task automatic set_chip(input cts_chip_t c);
		@(negedge ref_clk);
		chip_mode = c;
		tick(3);
	endtask

	task automatic clr_flags();
		@(negedge ref_clk);
		{wfc, ffc, ufc} = 3'h7;
		@(negedge ref_clk);
		{wfc, ffc, ufc} = 3'h0;
		tick(2);
	endtask

	// Two dominant phases split by a gap, then a long recessive tail
	task automatic wake(input int d1, input int g, input int d2);
		n_int = 0;
		n_rst = 0;
		n_wd = 0;
		@(negedge ref_clk);
		bus_dom = 1'h1;
		tick(d1);
		bus_dom = 1'h0;
		tick(g);
		bus_dom = 1'h1;
		tick(d2);
		bus_dom = 1'h0;
		tick(24);
	endtask

	task automatic pulses(input int ei, input int er, input int ew);
		chkn("int_n low", ei, n_int);
		chkn("chip_restart_req", er, n_rst);
		chkn("watchdog_enable_req", ew, n_wd);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{ref_clk, send_dom, ign_en, bus_dom, uv, mode_write, wfc, ffc, ufc, wd_dis, wd_obw} = '0;
		{n_fail, checks_done, cycles, n_int, n_rst, n_wd} = '0;
		mode_req = CTS_OFF;
		chip_mode = CHIP_INIT;
		rst = 1'h1;
		tick(2);
		rst = 1'h0;
		tick(1);
		chkm(CTS_OFF);
		chk1("rx_out", 1'h1, rx_out);
		chk1("driver_enable", 1'h0, drv_en);
		set_chip(CHIP_NORMAL);
		wake(6, 4, 6);
		chk1("bus_wake_flag", 1'h0, bwf);
		pulses(0, 0, 0);
		set_chip(CHIP_SLEEP);
		wr_mode(CTS_NORMAL);
		chkm(CTS_OFF);
		wr_mode(CTS_RXONLY);
		chkm(CTS_OFF);
		set_chip(CHIP_NORMAL);
		wr_mode(CTS_NORMAL);
		chkm(CTS_NORMAL);
		ign_en = 1'h1;
		send_dom = 1'h1;
		for (int i = 0; i < 40 && drv_en !== 1'h1; i++) @(negedge ref_clk);
		tick(5);
		chk1("driver_enable", 1'h1, drv_en);
		chk1("bus_drive_dominant", 1'h0, bdd);
		{ign_en, send_dom} = 2'h0;
		tick(4);
		send_dom = 1'h1;
		tick(6);
		chk1("bus_drive_dominant", 1'h1, bdd);
		send_dom = 1'h0;
		tick(6);
		chk1("bus_drive_dominant", 1'h0, bdd);
		bus_dom = 1'h1;
		tick(5);
		chk1("rx_out", 1'h0, rx_out);
		bus_dom = 1'h0;
		tick(5);
		chk1("rx_out", 1'h1, rx_out);
		send_dom = 1'h1;
		tick(45);
		chk1("driver_enable", 1'h0, drv_en);
		chk1("can_fail_flag", 1'h1, cff);
		chkm(CTS_NORMAL);
		send_dom = 1'h0;
		tick(6);
		chk1("driver_enable", 1'h1, drv_en);
		clr_flags();
		chk1("can_fail_flag", 1'h0, cff);
		uv = 1'h1;
		tick(6);
		chk1("undervolt_flag", 1'h1, uvf);
		chk1("driver_enable", 1'h0, drv_en);
		uv = 1'h0;
		tick(6);
		chk1("driver_enable", 1'h1, drv_en);
		chkm(CTS_NORMAL);
		wr_mode(CTS_RXONLY);
		chk1("driver_enable", 1'h0, drv_en);
		chk1("bus_bias_on", 1'h1, bias);
		bus_dom = 1'h1;
		tick(45);
		chk1("rx_out", 1'h0, rx_out);
		chk1("can_fail_flag", 1'h1, cff);
		chkm(CTS_RXONLY);
		bus_dom = 1'h0;
		clr_flags();
		wr_mode(CTS_WAKE);
		chkm(CTS_WAKE);
		wake(2, 4, 6);
		wake(6, 24, 6);
		chk1("bus_wake_flag", 1'h0, bwf);
		wake(6, 4, 6);
		pulses(1, 0, 0);
		chk1("bus_wake_flag", 1'h1, bwf);
		chk1("rx_out", 1'h0, rx_out);
		chkm(CTS_WAKE);
		clr_flags();
		wake(6, 4, 6);
		pulses(0, 0, 0);
		chk1("rx_out", 1'h0, rx_out);
		wr_mode(CTS_OFF);
		chk1("rx_out", 1'h1, rx_out);
		wr_mode(CTS_WAKE);
		wake(6, 4, 6);
		pulses(1, 0, 0);
		wd_dis = 1'h1;
		set_chip(CHIP_STOP);
		wake(6, 4, 6);
		pulses(1, 0, 0);
		wd_obw = 1'h1;
		wr_mode(CTS_OFF);
		wr_mode(CTS_WAKE);
		wake(6, 4, 6);
		pulses(1, 0, 1);
		chk1("rx_out", 1'h0, rx_out);
		set_chip(CHIP_SLEEP);
		wake(6, 4, 6);
		pulses(0, 1, 0);
		set_chip(CHIP_RESTART);
		wr_mode(CTS_OFF);
		chkm(CTS_OFF);
		wr_mode(CTS_WAKE);
		chkm(CTS_WAKE);
		wake(6, 4, 6);
		pulses(0, 1, 0);
		wr_mode(CTS_OFF);
		set_chip(CHIP_FAILSAFE);
		chkm(CTS_WAKE);
		wake(6, 4, 6);
		pulses(0, 1, 0);
		chk1("rx_out", 1'h0, rx_out);
		chip_mode = CHIP_INIT;
		rst = 1'h1;
		tick(2);
		rst = 1'h0;
		tick(1);
		chkm(CTS_OFF);
		chk1("rx_out", 1'h1, rx_out);
		end_of_test();
	end
endmodule
`default_nettype wire
